// [design/pll_memory_config_pkg.sv]
// Function
// - A 10-bit read/write PLL pre-divider field resets to zero and should be left at that value.
// - A 17-bit read/write PLL feedback divider field resets to 0x7FFA and a 4-bit read/write post divider field resets to zero.
// - Three PLL bandwidth selection fields reset to 0x0, 0x18 and 0xB and should not be modified.
// - Each internal SRAM bank gets wait states from its own 2-bit code, 00 none, 01 one, 11 two, reset zero.
// - Internal ROM accesses get wait states from a 2-bit code resetting to zero, 00 none, 01 one, 11 two.
// - Bit 0 of the misc register, reset zero, presents a self-refresh request to the memory controller.
// - Bit 3, reset zero and writable, makes static chip select 0 active high when one and active low when zero.
// - Bit 4, reset zero, makes static chip select 1 active high when one and active low when zero.
// - With bit 7 set, active lane selects of chip select 1 go low on reads and writes, else reads keep all four high.
// - With bit 8 low and a 16-bit static memory, external address 15..0 carries internal address 16..1.
// - With bit 8 high the internal address is not shifted for 16-bit memory and external line 0 is unused.
`default_nettype none
package pll_memory_config_pkg;

	// ****************************************************************
	// Register byte addresses.
	// ****************************************************************
	localparam logic [31:0] PLL_PRE_DIVIDER_ADDR = 32'h1300_2840;
	localparam logic [31:0] PLL_FEEDBACK_DIVIDER_ADDR = 32'h1300_2844;
	localparam logic [31:0] PLL_POST_DIVIDER_ADDR = 32'h1300_2848;
	localparam logic [31:0] PLL_BANDWIDTH_R_ADDR = 32'h1300_284c;
	localparam logic [31:0] PLL_BANDWIDTH_I_ADDR = 32'h1300_2850;
	localparam logic [31:0] PLL_BANDWIDTH_P_ADDR = 32'h1300_2854;
	localparam logic [31:0] SRAM_BANK0_WAIT_ADDR = 32'h1300_2858;
	localparam logic [31:0] SRAM_BANK1_WAIT_ADDR = 32'h1300_285c;
	localparam logic [31:0] ROM_WAIT_ADDR = 32'h1300_2860;
	localparam logic [31:0] STATIC_MEM_MISC_ADDR = 32'h1300_2864;

	// ****************************************************************
	// Field widths and reset values.
	// ****************************************************************
	localparam int PRE_W = 10;
	localparam int FB_W = 17;
	localparam int POST_W = 4;
	localparam int BW_W = 4;
	localparam int SELI_W = 5;
	localparam int WAIT_W = 2;
	localparam int MISC_W = 9;
	localparam logic [PRE_W-1:0] PRE_RST = 10'h000;
	localparam logic [FB_W-1:0] FB_RST = 17'h07ffa;
	localparam logic [POST_W-1:0] POST_RST = 4'h0;
	localparam logic [BW_W-1:0] SELR_RST = 4'h0;
	localparam logic [SELI_W-1:0] SELI_RST = 5'h18;
	localparam logic [BW_W-1:0] SELP_RST = 4'hb;
	localparam logic [WAIT_W-1:0] WAIT_RST = 2'h0;
	localparam logic [MISC_W-1:0] MISC_RST = 9'h000;

	// ****************************************************************
	// Misc register bit positions and writable mask.
	// ****************************************************************
	localparam int SREF_BIT = 0;
	localparam int CS0_POL_BIT = 3;
	localparam int CS1_POL_BIT = 4;
	localparam int CS1_LANE_BIT = 7;
	localparam int ADDR_MODE_BIT = 8;
	localparam logic [MISC_W-1:0] MISC_MASK = 9'h199;

	// ****************************************************************
	// Wait-state codes.
	// ****************************************************************
	localparam logic [WAIT_W-1:0] WAIT_NONE = 2'h0;
	localparam logic [WAIT_W-1:0] WAIT_ONE = 2'h1;
	localparam logic [WAIT_W-1:0] WAIT_TWO = 2'h3;

	// ****************************************************************
	// Carriers.
	// ****************************************************************
	typedef struct packed {
		logic [PRE_W-1:0] pre_divider;
		logic [FB_W-1:0] feedback_divider;
		logic [POST_W-1:0] post_divider;
		logic [BW_W-1:0] bandwidth_r;
		logic [SELI_W-1:0] bandwidth_i;
		logic [BW_W-1:0] bandwidth_p;
	} pll_cfg_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic cs1;
		logic memory_width16;
		logic [3:0] lanes;
		logic [31:0] addr;
	} smem_req_type;

endpackage
`default_nettype wire

// [design/wait_state_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module wait_state_gen (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Configuration and access handshake.
	input wire logic [pll_memory_config_pkg::WAIT_W-1:0] wait_code_i,
	input wire logic req_i,
	output logic ready_o
);
	import pll_memory_config_pkg::*;

	logic [1:0] count_q;
	logic busy_q;
	logic [1:0] waits;

	// ****************************************************************
	// Code decode.
	// ****************************************************************
	// The undefined code 10 is served as the slower setting, which is always safe.
	always_comb begin
		unique case (wait_code_i)
			WAIT_NONE: waits = 2'd0;
			WAIT_ONE: waits = 2'd1;
			default: waits = 2'd2;
		endcase
	end

	// Count the wait states; a request while busy is ignored.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_q <= 2'd0;
			busy_q <= 1'b0;
			ready_o <= 1'b0;
		end else begin
			ready_o <= 1'b0;
			if (busy_q) begin
				count_q <= count_q - 2'd1;
				if (count_q == 2'd1) begin
					busy_q <= 1'b0;
					ready_o <= 1'b1;
				end
			end else if (req_i) begin
				if (waits == 2'd0) begin
					ready_o <= 1'b1;
				end else begin
					busy_q <= 1'b1;
					count_q <= waits;
				end
			end
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	sequence req_idle_s;
		req_i && !busy_q && !ready_o;
	endsequence

	chk_zero_wait: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		req_idle_s and (wait_code_i == WAIT_NONE) |=> ready_o)
		else $error("zero wait code did not answer next cycle");
	chk_one_wait: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		req_idle_s and (wait_code_i == WAIT_ONE) |=> !ready_o ##1 ready_o)
		else $error("one wait code did not answer after one wait");
	chk_two_wait: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		req_idle_s and wait_code_i[1] |=> !ready_o [*2] ##1 ready_o)
		else $error("two wait code did not answer after two waits");

endmodule // wait_state_gen
`default_nettype wire

// [design/pll_memory_config_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module pll_memory_config_regs #(
	parameter int WAIT_PORTS = 3
) (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Register port.
	input wire logic [31:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	output logic [31:0] rd_data_o,
	// PLL configuration.
	output pll_memory_config_pkg::pll_cfg_type pll_cfg_o,
	// Internal memory wait handshake: 0 bank 0, 1 bank 1, 2 ROM.
	input wire logic [WAIT_PORTS-1:0] mem_req_i,
	output logic [WAIT_PORTS-1:0] mem_ready_o,
	// Static memory controller side.
	input wire pll_memory_config_pkg::smem_req_type smem_req_i,
	output logic self_refresh_req_o,
	output logic [1:0] chip_select_o,
	output logic [3:0] byte_lane_select_n_o,
	output logic [15:0] ext_addr_o
);
	import pll_memory_config_pkg::*;

	// The three wait registers map one to one onto the wait ports.
	if (WAIT_PORTS != 3) begin : g_bad_ports
		$error("WAIT_PORTS must be 3");
	end

	logic [WAIT_W-1:0] wait_code_q [WAIT_PORTS];
	logic [MISC_W-1:0] misc_q;
	logic [31:0] rd_data_d;
	logic cs0_polarity;
	logic cs1_polarity;
	logic cs1_lane_polarity;
	logic address_mode_select;

	assign cs0_polarity = misc_q[CS0_POL_BIT];
	assign cs1_polarity = misc_q[CS1_POL_BIT];
	assign cs1_lane_polarity = misc_q[CS1_LANE_BIT];
	assign address_mode_select = misc_q[ADDR_MODE_BIT];

	// ****************************************************************
	// PLL registers.
	// ****************************************************************
	// Only the low field bits are stored, so reserved bits ignore writes.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pll_cfg_o.pre_divider <= PRE_RST;
			pll_cfg_o.feedback_divider <= FB_RST;
			pll_cfg_o.post_divider <= POST_RST;
			pll_cfg_o.bandwidth_r <= SELR_RST;
			pll_cfg_o.bandwidth_i <= SELI_RST;
			pll_cfg_o.bandwidth_p <= SELP_RST;
		end else if (wr_en_i) begin
			unique case (addr_i)
				PLL_PRE_DIVIDER_ADDR: pll_cfg_o.pre_divider <= wr_data_i[PRE_W-1:0];
				PLL_FEEDBACK_DIVIDER_ADDR: pll_cfg_o.feedback_divider <= wr_data_i[FB_W-1:0];
				PLL_POST_DIVIDER_ADDR: pll_cfg_o.post_divider <= wr_data_i[POST_W-1:0];
				PLL_BANDWIDTH_R_ADDR: pll_cfg_o.bandwidth_r <= wr_data_i[BW_W-1:0];
				PLL_BANDWIDTH_I_ADDR: pll_cfg_o.bandwidth_i <= wr_data_i[SELI_W-1:0];
				PLL_BANDWIDTH_P_ADDR: pll_cfg_o.bandwidth_p <= wr_data_i[BW_W-1:0];
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Wait and misc registers.
	// ****************************************************************
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < WAIT_PORTS; i++) begin
				wait_code_q[i] <= WAIT_RST;
			end
			misc_q <= MISC_RST;
		end else if (wr_en_i) begin
			unique case (addr_i)
				SRAM_BANK0_WAIT_ADDR: wait_code_q[0] <= wr_data_i[WAIT_W-1:0];
				SRAM_BANK1_WAIT_ADDR: wait_code_q[1] <= wr_data_i[WAIT_W-1:0];
				ROM_WAIT_ADDR: wait_code_q[2] <= wr_data_i[WAIT_W-1:0];
				STATIC_MEM_MISC_ADDR: misc_q <= wr_data_i[MISC_W-1:0] & MISC_MASK;
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Read path.
	// ****************************************************************
	// Unmapped addresses read zero; data stand only in the cycle after the strobe.
	always_comb begin
		rd_data_d = 32'h0000_0000;
		unique case (addr_i)
			PLL_PRE_DIVIDER_ADDR: rd_data_d[PRE_W-1:0] = pll_cfg_o.pre_divider;
			PLL_FEEDBACK_DIVIDER_ADDR: rd_data_d[FB_W-1:0] = pll_cfg_o.feedback_divider;
			PLL_POST_DIVIDER_ADDR: rd_data_d[POST_W-1:0] = pll_cfg_o.post_divider;
			PLL_BANDWIDTH_R_ADDR: rd_data_d[BW_W-1:0] = pll_cfg_o.bandwidth_r;
			PLL_BANDWIDTH_I_ADDR: rd_data_d[SELI_W-1:0] = pll_cfg_o.bandwidth_i;
			PLL_BANDWIDTH_P_ADDR: rd_data_d[BW_W-1:0] = pll_cfg_o.bandwidth_p;
			SRAM_BANK0_WAIT_ADDR: rd_data_d[WAIT_W-1:0] = wait_code_q[0];
			SRAM_BANK1_WAIT_ADDR: rd_data_d[WAIT_W-1:0] = wait_code_q[1];
			ROM_WAIT_ADDR: rd_data_d[WAIT_W-1:0] = wait_code_q[2];
			STATIC_MEM_MISC_ADDR: rd_data_d[MISC_W-1:0] = misc_q;
			default: ;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_o <= 32'h0000_0000;
		end else if (rd_en_i) begin
			rd_data_o <= rd_data_d;
		end else begin
			rd_data_o <= 32'h0000_0000;
		end
	end

	// ****************************************************************
	// Wait-state generators.
	// ****************************************************************
	for (genvar g = 0; g < WAIT_PORTS; g++) begin : g_wait
		wait_state_gen u_wait (
			.clk_sys_i(clk_sys_i),
			.reset_n_i(reset_n_i),
			.wait_code_i(wait_code_q[g]),
			.req_i(mem_req_i[g]),
			.ready_o(mem_ready_o[g])
		);
	end

	// ****************************************************************
	// Static memory outputs.
	// ****************************************************************
	// The misc bit is copied to the request output so the controller sees a clean flop.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			self_refresh_req_o <= 1'b0;
		end else begin
			self_refresh_req_o <= misc_q[SREF_BIT];
		end
	end

	// Idle selects sit at their inactive level, which follows the polarity bit.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			chip_select_o <= 2'b11;
		end else begin
			chip_select_o[0] <= (smem_req_i.valid && !smem_req_i.cs1) ~^ cs0_polarity;
			chip_select_o[1] <= (smem_req_i.valid && smem_req_i.cs1) ~^ cs1_polarity;
		end
	end

	// Chip select 0 always keeps lanes high on reads; only chip select 1 has the option.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			byte_lane_select_n_o <= 4'hf;
		end else if (smem_req_i.valid && (smem_req_i.write || (smem_req_i.cs1 && cs1_lane_polarity))) begin
			byte_lane_select_n_o <= ~smem_req_i.lanes;
		end else begin
			byte_lane_select_n_o <= 4'hf;
		end
	end

	// A 16-bit part in unshifted mode leaves line 0 unused; it is driven low.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ext_addr_o <= 16'h0000;
		end else if (smem_req_i.valid) begin
			if (smem_req_i.memory_width16 && !address_mode_select) begin
				ext_addr_o <= smem_req_i.addr[16:1];
			end else if (smem_req_i.memory_width16) begin
				ext_addr_o <= {smem_req_i.addr[15:1], 1'b0};
			end else begin
				ext_addr_o <= smem_req_i.addr[15:0];
			end
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	sequence wr_s(logic [31:0] a);
		wr_en_i && (addr_i == a);
	endsequence

	sequence rd_s(logic [31:0] a);
		rd_en_i && (addr_i == a);
	endsequence

	// A write, one quiet cycle, then a read of the same register; the quiet cycle keeps a second write out.
	sequence wr_gap_rd_s(logic [31:0] a);
		wr_s(a) ##1 !wr_en_i ##1 rd_s(a);
	endsequence

	chk_pre_div_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_s(PLL_PRE_DIVIDER_ADDR) |=> pll_cfg_o.pre_divider == $past(wr_data_i[PRE_W-1:0]))
		else $error("pre-divider did not take the write");
	chk_fb_div_readback: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_gap_rd_s(PLL_FEEDBACK_DIVIDER_ADDR)
		|=> rd_data_o == {15'h0000, $past(wr_data_i[FB_W-1:0], 3)})
		else $error("feedback divider readback wrong");
	chk_bw_p_readback: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_gap_rd_s(PLL_BANDWIDTH_P_ADDR)
		|=> rd_data_o == {28'h0000000, $past(wr_data_i[BW_W-1:0], 3)})
		else $error("bandwidth p readback wrong");
	chk_self_refresh: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_s(STATIC_MEM_MISC_ADDR) |=> ##1 self_refresh_req_o == $past(wr_data_i[SREF_BIT], 2))
		else $error("self refresh request does not follow bit 0");
	chk_cs0_active: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		smem_req_i.valid && !smem_req_i.cs1 |=> chip_select_o[0] == $past(cs0_polarity) && chip_select_o[1] != $past(cs1_polarity))
		else $error("chip select 0 level wrong");
	chk_cs1_active: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		smem_req_i.valid && smem_req_i.cs1 |=> chip_select_o[1] == $past(cs1_polarity) && chip_select_o[0] != $past(cs0_polarity))
		else $error("chip select 1 level wrong");
	chk_lane_read: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		smem_req_i.valid && !smem_req_i.write && smem_req_i.cs1
		|=> byte_lane_select_n_o == ($past(cs1_lane_polarity) ? ~$past(smem_req_i.lanes) : 4'hf))
		else $error("chip select 1 read lanes wrong");
	chk_addr_shift: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		smem_req_i.valid && smem_req_i.memory_width16 && !address_mode_select
		|=> ext_addr_o == $past(smem_req_i.addr[16:1]))
		else $error("shifted address wrong");
	chk_addr_noshift: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		smem_req_i.valid && smem_req_i.memory_width16 && address_mode_select
		|=> ext_addr_o[15:1] == $past(smem_req_i.addr[15:1]) && !ext_addr_o[0])
		else $error("unshifted address wrong");
	chk_misc_reserved: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		rd_s(STATIC_MEM_MISC_ADDR) |=> rd_data_o[31:9] == 23'h000000 && rd_data_o[6:5] == 2'h0 && rd_data_o[2:1] == 2'h0)
		else $error("misc reserved bits not zero");

	// ****************************************************************
	// Field write checks.
	// ****************************************************************
	// Each field must take exactly its own low write bits; a wrong slice would leave stale bits behind.
	chk_fb_div_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_s(PLL_FEEDBACK_DIVIDER_ADDR) |=> pll_cfg_o.feedback_divider == $past(wr_data_i[FB_W-1:0]))
		else $error("feedback divider did not take the write");
	chk_post_div_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_s(PLL_POST_DIVIDER_ADDR) |=> pll_cfg_o.post_divider == $past(wr_data_i[POST_W-1:0]))
		else $error("post divider did not take the write");
	chk_bw_r_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_s(PLL_BANDWIDTH_R_ADDR) |=> pll_cfg_o.bandwidth_r == $past(wr_data_i[BW_W-1:0]))
		else $error("bandwidth r did not take the write");
	chk_bw_i_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_s(PLL_BANDWIDTH_I_ADDR) |=> pll_cfg_o.bandwidth_i == $past(wr_data_i[SELI_W-1:0]))
		else $error("bandwidth i did not take the write");
	chk_bw_p_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_s(PLL_BANDWIDTH_P_ADDR) |=> pll_cfg_o.bandwidth_p == $past(wr_data_i[BW_W-1:0]))
		else $error("bandwidth p did not take the write");

	// Reserved bits above each field must read zero whatever was written there.
	chk_pre_div_reserved: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		rd_s(PLL_PRE_DIVIDER_ADDR) |=> rd_data_o[31:PRE_W] == 22'h000000)
		else $error("pre-divider reserved bits not zero");
	chk_fb_div_reserved: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		rd_s(PLL_FEEDBACK_DIVIDER_ADDR) |=> rd_data_o[31:FB_W] == 15'h0000)
		else $error("feedback divider reserved bits not zero");
	chk_bw_i_reserved: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		rd_s(PLL_BANDWIDTH_I_ADDR) |=> rd_data_o[31:SELI_W] == 27'h0000000)
		else $error("bandwidth i reserved bits not zero");
	chk_misc_store_mask: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_s(STATIC_MEM_MISC_ADDR) |=> (misc_q & ~MISC_MASK) == 9'h000)
		else $error("misc reserved bits were stored");

	// ****************************************************************
	// Wait and misc readback checks.
	// ****************************************************************
	// The wait codes feed the generators directly, so a lost write would silently change memory timing.
	chk_bank0_readback: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_gap_rd_s(SRAM_BANK0_WAIT_ADDR)
		|=> rd_data_o == {30'h0, $past(wr_data_i[WAIT_W-1:0], 3)})
		else $error("bank 0 wait readback wrong");
	chk_bank1_readback: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_gap_rd_s(SRAM_BANK1_WAIT_ADDR)
		|=> rd_data_o == {30'h0, $past(wr_data_i[WAIT_W-1:0], 3)})
		else $error("bank 1 wait readback wrong");
	chk_rom_readback: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_gap_rd_s(ROM_WAIT_ADDR)
		|=> rd_data_o == {30'h0, $past(wr_data_i[WAIT_W-1:0], 3)})
		else $error("rom wait readback wrong");
	chk_misc_readback: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_gap_rd_s(STATIC_MEM_MISC_ADDR)
		|=> rd_data_o == {23'h000000, $past(wr_data_i[MISC_W-1:0], 3) & MISC_MASK})
		else $error("misc readback wrong");

	// ****************************************************************
	// Read bus checks.
	// ****************************************************************
	// Read data stand for one cycle only; a stale word would look like a second answer.
	chk_unmapped_read: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		rd_en_i && (addr_i < PLL_PRE_DIVIDER_ADDR || addr_i > STATIC_MEM_MISC_ADDR || addr_i[1:0] != 2'h0)
		|=> rd_data_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_read_idle: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		!rd_en_i |=> rd_data_o == 32'h0000_0000)
		else $error("read data not zero outside the read cycle");

	// ****************************************************************
	// Static memory checks.
	// ****************************************************************
	// Writes always drive the active lanes low, on either chip select.
	chk_lane_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		smem_req_i.valid && smem_req_i.write |=> byte_lane_select_n_o == ~$past(smem_req_i.lanes))
		else $error("write lanes wrong");
	chk_lane_cs0_read: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		smem_req_i.valid && !smem_req_i.write && !smem_req_i.cs1 |=> byte_lane_select_n_o == 4'hf)
		else $error("chip select 0 read lanes wrong");
	chk_cs_idle: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		!smem_req_i.valid |=> chip_select_o == ~{$past(cs1_polarity), $past(cs0_polarity)})
		else $error("idle chip selects not inactive");

	// An 8-bit part is never shifted, and between accesses the address lines must not move.
	chk_addr_narrow: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		smem_req_i.valid && !smem_req_i.memory_width16 |=> ext_addr_o == $past(smem_req_i.addr[15:0]))
		else $error("8-bit address wrong");
	chk_addr_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		!smem_req_i.valid |=> $stable(ext_addr_o))
		else $error("address moved while idle");

endmodule // pll_memory_config_regs
`default_nettype wire

// [verification/tb_pll_memory_config_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_pll_memory_config_regs;
	import pll_memory_config_pkg::*;

	// ****************************************************************
	// Stimulus and observed signals.
	// ****************************************************************
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [31:0] addr_i = 32'h0;
	logic [31:0] wr_data_i = 32'h0;
	logic wr_en_i = 1'b0;
	logic rd_en_i = 1'b0;
	logic [31:0] rd_data_o;
	pll_cfg_type pll_cfg_o;
	logic [2:0] mem_req_i = 3'h0;
	logic [2:0] mem_ready_o;
	smem_req_type smem_req_i = '0;
	logic self_refresh_req_o;
	logic [1:0] chip_select_o;
	logic [3:0] byte_lane_select_n_o;
	logic [15:0] ext_addr_o;
	int bad_count = 0;
	int comparisons = 0;
	logic [31:0] rst_val [10] = '{32'h0, 32'h7ffa, 32'h0, 32'h0, 32'h18, 32'hb, 32'h0, 32'h0, 32'h0, 32'h0};
	logic [31:0] wr_mask [10] = '{32'h3ff, 32'h1ffff, 32'hf, 32'hf, 32'h1f, 32'hf, 32'h3, 32'h3, 32'h3, 32'h199};
	logic [8:0] misc_set [4] = '{9'h000, 9'h199, 9'h088, 9'h110};

	pll_memory_config_regs #(.WAIT_PORTS(3)) dut (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .pll_cfg_o(pll_cfg_o),
		.mem_req_i(mem_req_i), .mem_ready_o(mem_ready_o), .smem_req_i(smem_req_i),
		.self_refresh_req_o(self_refresh_req_o), .chip_select_o(chip_select_o),
		.byte_lane_select_n_o(byte_lane_select_n_o), .ext_addr_o(ext_addr_o)
	);

	// 40 MHz system clock.
	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	// ****************************************************************
	// Shared tasks.
	// ****************************************************************
	// Compares with case equality so an unknown never passes.
	task automatic check(input logic [43:0] seen, input logic [43:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle write strobe; the next edge releases it.
	task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		wr_en_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge clk_sys_i);
		wr_en_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there.
	task automatic reg_read(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		rd_en_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_en_i <= 1'b0;
		#1 d = rd_data_o;
	endtask

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	task automatic test_reset_values();
		logic [31:0] d;
		#1;
		check(pll_cfg_o, {PRE_RST, FB_RST, POST_RST, SELR_RST, SELI_RST, SELP_RST});
		check({self_refresh_req_o, chip_select_o}, 3'b011);
		for (int i = 0; i < 10; i++) begin
			reg_read(PLL_PRE_DIVIDER_ADDR + 32'(4 * i), d);
			check(d, rst_val[i]);
		end
		@(posedge clk_sys_i);
		#1;
		check(rd_data_o, 32'h0);
		$display("Test reset values done");
	endtask

	// All ones written everywhere: reserved bits must stay zero.
	task automatic test_write_mask();
		logic [31:0] d;
		for (int i = 0; i < 10; i++) begin
			reg_write(PLL_PRE_DIVIDER_ADDR + 32'(4 * i), 32'hffff_ffff);
			reg_read(PLL_PRE_DIVIDER_ADDR + 32'(4 * i), d);
			check(d, wr_mask[i]);
		end
		check(pll_cfg_o, {44{1'b1}});
		reg_write(32'h1300_2868, 32'hffff_ffff);
		reg_read(32'h1300_2868, d);
		check(d, 32'h0);
		$display("Test write mask done");
	endtask

	// Ready comes 1+N cycles after the request, code 10 counting as two.
	task automatic test_wait_states();
		int k;
		for (int p = 0; p < 3; p++) begin
			for (int c = 0; c < 4; c++) begin
				reg_write(SRAM_BANK0_WAIT_ADDR + 32'(4 * p), 32'(c));
				@(posedge clk_sys_i);
				mem_req_i <= 3'(1 << p);
				@(posedge clk_sys_i);
				mem_req_i <= 3'h0;
				k = 1;
				#1;
				while (mem_ready_o[p] !== 1'b1 && k < 8) begin
					@(posedge clk_sys_i);
					#1 k++;
				end
				check(44'(k), 44'((c == 0) ? 1 : (c == 1) ? 2 : 3));
				@(posedge clk_sys_i);
				#1;
				check(mem_ready_o, 3'h0);
			end
		end
		$display("Test wait states done");
	endtask

	// Chip selects, lane selects, address mapping and self refresh per misc setting.
	task automatic test_static_mem();
		logic [31:0] a;
		logic [3:0] ln;
		logic [8:0] m;
		logic w, c, s;
		a = 32'h0001_a5a5;
		ln = 4'h6;
		for (int i = 0; i < 4; i++) begin
			m = misc_set[i];
			reg_write(STATIC_MEM_MISC_ADDR, 32'(m));
			for (int j = 0; j < 8; j++) begin
				{w, c, s} = 3'(j);
				@(posedge clk_sys_i);
				smem_req_i <= {1'b1, w, c, s, ln, a};
				@(posedge clk_sys_i);
				#1;
				check(self_refresh_req_o, m[0]);
				check(chip_select_o[0], c ? !m[3] : m[3]);
				check(chip_select_o[1], c ? m[4] : !m[4]);
				check(byte_lane_select_n_o, (w || (c && m[7])) ? 4'(~ln) : 4'hf);
				check(ext_addr_o, s ? (m[8] ? {a[15:1], 1'b0} : a[16:1]) : a[15:0]);
			end
		end
		$display("Test static memory done");
	endtask

	// ****************************************************************
	// Closing report and main sequence.
	// ****************************************************************
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Cuts a hang short well beyond the few hundred cycles the tests need.
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		bad_count++;
		complete_run();
	end

	initial begin
		repeat (12) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		@(posedge clk_sys_i);
		test_reset_values();
		test_write_mask();
		test_wait_states();
		test_static_mem();
		// A second reset after every register was rewritten must restore the power-on values.
		@(posedge clk_sys_i);
		smem_req_i <= '0;
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		@(posedge clk_sys_i);
		test_reset_values();
		complete_run();
	end

endmodule // tb_pll_memory_config_regs
`default_nettype wire
